// [logic/tbs_pkg.sv]
/*
  Shared constants and carriers of the tile boot source loader.
  Assumes a 100 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package tbs_pkg;
  // Clock rates
  localparam int CLK_PERIOD_NS = 10;
  localparam int CORE_REF_KHZ = 400000;
  localparam int QUAD_SCLK_KHZ = 50000;
  localparam int SINGLE_SCLK_KHZ = 2500;
  localparam int LINK_EN_NS = 2000;
  localparam int LINK_TX_PERIOD_NS = 160;
  // Half periods and the link enable delay in core cycles, minus one for terminal counts
  localparam logic [7:0] QUAD_HALF_M1 =
    8'(CORE_REF_KHZ / QUAD_SCLK_KHZ / 2 - 1);
  localparam logic [7:0] SINGLE_HALF_M1 =
    8'(CORE_REF_KHZ / SINGLE_SCLK_KHZ / 2 - 1);
  localparam logic [7:0] LINK_EN_M1 = 8'(LINK_EN_NS / CLK_PERIOD_NS - 1);
  localparam logic [7:0] LINK_HALF_M1 =
    8'(LINK_TX_PERIOD_NS / CLK_PERIOD_NS / 2 - 1);
  // Flash command
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] FLASH_START_ADDR = 24'h000000;
  // Image check
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;
  // Link tokens
  localparam logic [31:0] NULL_CHANEND = 32'h0000ff02;
  localparam logic [7:0] END_TOKEN = 8'h01;
  localparam logic [10:0] OTP_BOOT_ADDR = 11'h000;
  // Protection word fields
  localparam int PROT_TAP_OFF = 0;
  localparam int PROT_LINK_OFF = 1;
  localparam int PROT_SECURE = 5;
  localparam int PROT_REDUND = 7;
  localparam int PROT_SLOCK_LO = 8;
  localparam int PROT_MLOCK = 12;
  localparam int PROT_TAP_OTP = 13;
  localparam int PROT_GP_LO = 15;
  localparam int PROT_GP_HI = 21;
  localparam int PROT_UID_LO = 22;
  // Register byte offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PROT = 8'h08;
  localparam logic [7:0] REG_SIZE = 8'h0c;
  localparam logic [7:0] REG_WORDS = 8'h10;
  localparam logic [7:0] REG_CRC = 8'h14;
  localparam logic [7:0] REG_ACK = 8'h18;
  localparam int CTRL_START_BIT = 4;

  typedef enum logic [1:0] {SRC_QUAD, SRC_SINGLE, SRC_SLAVE, SRC_LINK}
    tbs_src_t;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [31:0] data;
  } tbs_word_t;
  typedef struct packed {
    logic tap_block;
    logic switch_block;
    logic redundant_en;
    logic [3:0] sector_lock;
    logic master_lock;
    logic tap_otp_block;
    logic [9:0] usercode_ext;
  } tbs_prot_t;
endpackage : tbs_pkg

// [logic/tbs_sync_edge.sv]
/*
  Two-flop synchroniser for a group of pins, with edge detect on bit 0.
  Assumes the group is sampled together and bit 0 is a slow clock.
*/
module tbs_sync_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pins, bit 0 is a clock
  input wire logic [W-1:0] async_in,
  // Synchronised levels and bit 0 edges
  output logic [W-1:0] sync_out,
  output logic rise,
  output logic fall
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic last_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg[0];
    end
  end

  // Edges judged on the second stage only
  assign sync_out = sync_reg;
  assign rise = sync_reg[0] & ~last_reg;
  assign fall = ~sync_reg[0] & last_reg;
endmodule : tbs_sync_edge

// [logic/tbs_crc32.sv]
/*
  Byte-wide reflected CRC-32 accumulator for the boot image.
  Assumes clear and byte_en come from logic on the same clock.
*/
module tbs_crc32
  import tbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Byte stream
  input wire logic clear,
  input wire logic byte_en,
  input wire logic [7:0] byte_in,
  // Inverted residue
  output logic [31:0] crc_out
);
  logic [31:0] crc_reg;

  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  always_ff @(posedge clk_sys) begin
    if (!reset_n || clear) begin
      crc_reg <= CRC_INIT;
    end else if (byte_en) begin
      crc_reg <= crc_step(crc_reg, byte_in);
    end
  end

  assign crc_out = ~crc_reg;
endmodule : tbs_crc32

// [logic/tbs_boot_loader.sv]
/*
  Tile boot loader: fetches a boot image from quad or single SPI flash,
  an SPI host, a link or on-chip OTP, checks it and streams image words.
  Assumes a 100 MHz clk_sys, AHB-Lite with hreadyout as bus hready, an
  OTP read port with one cycle of latency and pins from another domain.
*/
module tbs_boot_loader
  import tbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // OTP
  input wire logic [31:0] otp_prot_word,
  output logic otp_rd_en,
  output logic [10:0] otp_rd_addr,
  input wire logic [31:0] otp_rd_data,
  // SPI pins
  input wire logic spi_cs_n_i,
  output logic spi_cs_n_o,
  output logic spi_cs_n_oe,
  input wire logic spi_sclk_i,
  output logic spi_sclk_o,
  output logic spi_sclk_oe,
  input wire logic spi_mosi_i,
  output logic spi_mosi_o,
  output logic spi_mosi_oe,
  input wire logic spi_miso_i,
  input wire logic [3:0] quad_data_lines_i,
  output logic [3:0] quad_data_lines_o,
  output logic [3:0] quad_data_lines_oe,
  // Link
  input wire logic link_rx_clk,
  input wire logic link_rx_ctrl,
  input wire logic [7:0] link_rx_data,
  output logic link_tx_clk,
  output logic link_tx_ctrl,
  output logic [7:0] link_tx_data,
  output logic link_enable,
  output logic link_pulldown_en,
  // Image stream and tile controls
  output tbs_word_t img_word,
  output logic chanend0_alloc,
  output logic exec_start,
  output tbs_prot_t prot_ctl
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SPI_CMD, ST_SPI_DATA, ST_SLAVE, ST_LINK_WAIT, ST_LINK_RX,
    ST_LINK_ACK, ST_OTP_REQ, ST_OTP_CAP, ST_OTP_BYTES, ST_DONE, ST_FAIL
  } tbs_state_t;
  typedef enum logic [2:0] {PH_ACK, PH_SIZE, PH_PROG, PH_CRC, PH_END}
    tbs_phase_t;

  function automatic logic [7:0] byte_of(input logic [31:0] w,
                                         input logic [1:0] i);
    return w[{i, 3'b000} +: 8];
  endfunction : byte_of

  tbs_state_t state_reg, state_next, start_state;
  tbs_phase_t phase_reg;
  tbs_src_t src_reg;
  logic ahb_wr_reg;
  logic [7:0] ahb_addr_reg;
  logic [31:0] hrdata_reg, rd_mux;
  logic [31:0] prot_reg, size_reg, words_reg, ack_reg, word_sr_reg;
  logic [31:0] cmd_sr_reg, otp_word_reg, crc_val, full_word;
  logic prot_loaded_reg, crc_ok_reg, crc_skip_reg, exec_fired_reg;
  logic [7:0] cnt_reg, cnt_m1, rx_sr_reg, rx_next, rxb_reg;
  logic [4:0] bit_cnt_reg;
  logic [1:0] bcnt_reg;
  logic [2:0] tx_idx_reg;
  logic [10:0] otp_addr_reg;
  logic sclk_reg, cs_n_reg, mst_en_reg, quad_en_reg, rxb_valid_reg;
  logic link_en_reg, tx_clk_reg, tx_ctrl_reg, chan_reg, exec_reg;
  logic [7:0] tx_data_reg;
  tbs_word_t img_reg;
  logic [4:0] mst_s;
  logic [2:0] slv_s;
  logic [9:0] lnk_s;
  logic slv_rise, lnk_rise;

  // Pin synchronisers
  tbs_sync_edge #(.W(5)) u_sync_mst (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .async_in({quad_data_lines_i, spi_miso_i}),
    .sync_out(mst_s), .rise(), .fall());
  tbs_sync_edge #(.W(3)) u_sync_slv (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .async_in({spi_mosi_i, spi_cs_n_i, spi_sclk_i}),
    .sync_out(slv_s), .rise(slv_rise), .fall());
  tbs_sync_edge #(.W(10)) u_sync_lnk (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .async_in({link_rx_data, link_rx_ctrl, link_rx_clk}),
    .sync_out(lnk_s), .rise(lnk_rise), .fall());

  // Bus decode
  wire ahb_act = hsel & htrans[1] & hready;
  wire wr_ctrl = ahb_wr_reg & (ahb_addr_reg == REG_CTRL);
  wire wr_prot = ahb_wr_reg & (ahb_addr_reg == REG_PROT);
  wire idle_like = (state_reg == ST_IDLE) | (state_reg == ST_DONE) |
                   (state_reg == ST_FAIL);
  // Start ignored while a boot runs
  wire start = wr_ctrl & hwdata[CTRL_START_BIT] & idle_like;
  wire [1:0] wr_src = hwdata[1:0];
  wire secure = prot_reg[PROT_SECURE];

  // Timing
  wire is_quad = (src_reg == SRC_QUAD);
  wire in_spi = (state_reg == ST_SPI_CMD) | (state_reg == ST_SPI_DATA);
  assign cnt_m1 = (state_reg == ST_LINK_WAIT) ? LINK_EN_M1 :
                  (state_reg == ST_LINK_ACK) ? LINK_HALF_M1 :
                  is_quad ? QUAD_HALF_M1 : SINGLE_HALF_M1;
  wire tick = (cnt_reg == cnt_m1);
  // Master clock idles low; data sampled just before each falling edge
  wire spi_fall = in_spi & tick & sclk_reg;

  // Serial byte assembly
  wire slv_shift = (state_reg == ST_SLAVE) & slv_rise & ~slv_s[1];
  wire mst_shift = (state_reg == ST_SPI_DATA) & spi_fall;
  wire shift_en = slv_shift | mst_shift;
  assign rx_next = (state_reg == ST_SLAVE) ? {slv_s[2], rx_sr_reg[7:1]} :
                   is_quad ? {mst_s[4:1], rx_sr_reg[7:4]} :
                   {mst_s[0], rx_sr_reg[7:1]};
  wire byte_last = (mst_shift & is_quad) ? bit_cnt_reg[0] :
                   (bit_cnt_reg[2:0] == 3'd7);
  wire cmd_last = (bit_cnt_reg == 5'd31);

  // Link receive
  wire lnk_in = (state_reg == ST_LINK_RX) & lnk_rise;
  wire lnk_byte = lnk_in & ~lnk_s[1];
  wire lnk_end = lnk_in & lnk_s[1] & (lnk_s[9:2] == END_TOKEN);
  wire ack_null = (ack_reg == NULL_CHANEND);
  wire tx_last = (state_reg == ST_LINK_ACK) & tick & tx_clk_reg &
                 (tx_idx_reg == 3'd4);

  // Common byte stream
  wire byte_valid = (((state_reg == ST_SPI_DATA) | (state_reg == ST_SLAVE))
                     & rxb_valid_reg) | lnk_byte |
                    (state_reg == ST_OTP_BYTES);
  wire [7:0] byte_data = (state_reg == ST_LINK_RX) ? lnk_s[9:2] :
                         (state_reg == ST_OTP_BYTES) ?
                         byte_of(otp_word_reg, bit_cnt_reg[1:0]) : rxb_reg;
  assign full_word = {byte_data, word_sr_reg[31:8]};
  wire word_fire = byte_valid & (bcnt_reg == 2'd3);
  wire crc_en = byte_valid &
                ((phase_reg == PH_SIZE) | (phase_reg == PH_PROG));
  wire image_end = word_fire & (phase_reg == PH_CRC);
  wire crc_good = (full_word == CRC_SKIP) | (full_word == crc_val);
  wire last_prog = (words_reg + 32'd1 == size_reg);

  tbs_crc32 u_crc (
    .clk_sys(clk_sys), .reset_n(reset_n), .clear(start),
    .byte_en(crc_en), .byte_in(byte_data), .crc_out(crc_val));

  assign start_state = secure ? ST_OTP_REQ :
    ((wr_src == SRC_QUAD) | (wr_src == SRC_SINGLE)) ? ST_SPI_CMD :
    (wr_src == SRC_SLAVE) ? ST_SLAVE : ST_LINK_WAIT;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE, ST_DONE, ST_FAIL: begin
        if (start) state_next = start_state;
      end
      ST_SPI_CMD: begin
        if (spi_fall && cmd_last) state_next = ST_SPI_DATA;
      end
      ST_SPI_DATA, ST_SLAVE: begin
        if (image_end) state_next = crc_good ? ST_DONE : ST_FAIL;
      end
      ST_OTP_REQ: state_next = ST_OTP_CAP;
      ST_OTP_CAP: state_next = ST_OTP_BYTES;
      ST_OTP_BYTES: begin
        if (image_end) begin
          state_next = crc_good ? ST_DONE : ST_FAIL;
        end else if (bit_cnt_reg[1:0] == 2'd3) begin
          state_next = ST_OTP_REQ;
        end
      end
      ST_LINK_WAIT: begin
        if (tick) state_next = ST_LINK_RX;
      end
      ST_LINK_RX: begin
        if (lnk_end) begin
          if (phase_reg != PH_END) state_next = ST_FAIL;
          else if (!ack_null) state_next = ST_LINK_ACK;
          else state_next = crc_ok_reg ? ST_DONE : ST_FAIL;
        end
      end
      ST_LINK_ACK: begin
        if (tx_last) state_next = crc_ok_reg ? ST_DONE : ST_FAIL;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Bus slave: zero wait state, read data registered in address phase
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ahb_wr_reg <= 1'b0;
      ahb_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      ahb_wr_reg <= ahb_act & hwrite;
      if (ahb_act) ahb_addr_reg <= haddr[7:0];
      if (ahb_act && !hwrite) hrdata_reg <= rd_mux;
    end
  end

  wire [31:0] status_word = {24'h000000, state_reg == ST_FAIL,
                             state_reg == ST_DONE, crc_skip_reg,
                             crc_ok_reg, 4'(state_reg)};
  assign rd_mux = (haddr[7:0] == REG_CTRL) ? {30'h00000000, src_reg} :
                  (haddr[7:0] == REG_STATUS) ? status_word :
                  (haddr[7:0] == REG_PROT) ? prot_reg :
                  (haddr[7:0] == REG_SIZE) ? size_reg :
                  (haddr[7:0] == REG_WORDS) ? words_reg :
                  (haddr[7:0] == REG_CRC) ? crc_val :
                  (haddr[7:0] == REG_ACK) ? ack_reg : 32'h00000000;

  // Protection word: copied once after reset, general field writable
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prot_reg <= 32'h00000000;
      prot_loaded_reg <= 1'b0;
      src_reg <= SRC_QUAD;
    end else begin
      prot_loaded_reg <= 1'b1;
      if (!prot_loaded_reg) prot_reg <= otp_prot_word;
      else if (wr_prot) begin
        prot_reg[PROT_GP_HI:PROT_GP_LO] <=
          hwdata[PROT_GP_HI:PROT_GP_LO];
      end
      if (start) src_reg <= tbs_src_t'(wr_src);
    end
  end

  // Shared counters
  always_ff @(posedge clk_sys) begin
    if (!reset_n || start || tick || state_next != state_reg) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || start || state_next != state_reg) begin
      bit_cnt_reg <= 5'd0;
    end else if ((state_reg == ST_SLAVE) && slv_s[1]) begin
      bit_cnt_reg <= 5'd0;
    end else if (shift_en) begin
      bit_cnt_reg <= byte_last ? 5'd0 : bit_cnt_reg + 5'd1;
    end else if ((state_reg == ST_SPI_CMD && spi_fall) ||
                 state_reg == ST_OTP_BYTES) begin
      bit_cnt_reg <= bit_cnt_reg + 5'd1;
    end
  end

  // SPI master pins and shift registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mst_en_reg <= 1'b0;
      quad_en_reg <= 1'b0;
      cmd_sr_reg <= 32'h00000000;
    end else begin
      sclk_reg <= (in_spi && tick) ? ~sclk_reg : (sclk_reg & in_spi);
      cs_n_reg <= ~((state_next == ST_SPI_CMD) |
                    (state_next == ST_SPI_DATA));
      if (start) begin
        mst_en_reg <= (start_state == ST_SPI_CMD);
        quad_en_reg <= (start_state == ST_SPI_CMD) & (wr_src == SRC_QUAD);
        cmd_sr_reg <= {FLASH_READ_CMD, FLASH_START_ADDR};
      end else if (state_reg == ST_SPI_CMD && spi_fall) begin
        cmd_sr_reg <= {cmd_sr_reg[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rx_sr_reg <= 8'h00;
      rxb_reg <= 8'h00;
      rxb_valid_reg <= 1'b0;
    end else begin
      if (shift_en) rx_sr_reg <= rx_next;
      rxb_valid_reg <= shift_en & byte_last;
      if (shift_en && byte_last) rxb_reg <= rx_next;
    end
  end

  // Image assembly
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase_reg <= PH_SIZE;
      bcnt_reg <= 2'd0;
      word_sr_reg <= 32'h00000000;
      words_reg <= 32'h00000000;
      size_reg <= 32'h00000000;
      ack_reg <= NULL_CHANEND;
      crc_ok_reg <= 1'b0;
      crc_skip_reg <= 1'b0;
    end else if (start) begin
      phase_reg <= (start_state == ST_LINK_WAIT) ? PH_ACK : PH_SIZE;
      bcnt_reg <= 2'd0;
      words_reg <= 32'h00000000;
      crc_ok_reg <= 1'b0;
      crc_skip_reg <= 1'b0;
    end else if (byte_valid) begin
      word_sr_reg <= full_word;
      bcnt_reg <= bcnt_reg + 2'd1;
      if (word_fire) begin
        unique case (phase_reg)
          PH_ACK: begin
            ack_reg <= full_word;
            phase_reg <= PH_SIZE;
          end
          PH_SIZE: begin
            size_reg <= full_word;
            phase_reg <= (full_word == 32'h00000000) ? PH_CRC : PH_PROG;
          end
          PH_PROG: begin
            words_reg <= words_reg + 32'd1;
            if (last_prog) phase_reg <= PH_CRC;
          end
          PH_CRC: begin
            crc_ok_reg <= crc_good;
            crc_skip_reg <= (full_word == CRC_SKIP);
            phase_reg <= PH_END;
          end
          PH_END: phase_reg <= PH_END;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      img_reg <= '0;
    end else begin
      img_reg.valid <= word_fire & (phase_reg == PH_PROG);
      if (word_fire) begin
        img_reg.addr <= words_reg[15:0];
        img_reg.data <= full_word;
      end
    end
  end

  // OTP fetch, one word at a time
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      otp_addr_reg <= OTP_BOOT_ADDR;
      otp_word_reg <= 32'h00000000;
    end else begin
      if (start) otp_addr_reg <= OTP_BOOT_ADDR;
      else if (state_reg == ST_OTP_REQ) otp_addr_reg <= otp_addr_reg + 11'd1;
      if (state_reg == ST_OTP_CAP) otp_word_reg <= otp_rd_data;
    end
  end

  // Link: enable, acknowledge, release
  always_ff @(posedge clk_sys) begin
    if (!reset_n || start) begin
      link_en_reg <= 1'b0;
    end else if (state_reg == ST_LINK_WAIT && tick) begin
      link_en_reg <= 1'b1;
    end
  end

  // Receive wires are ignored until enabled; the pull-downs hold them low until then
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      chan_reg <= 1'b0;
    end else begin
      chan_reg <= (state_next == ST_LINK_RX) |
                  (state_next == ST_LINK_ACK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || state_reg != ST_LINK_ACK) begin
      tx_clk_reg <= 1'b0;
      tx_idx_reg <= 3'd0;
      tx_ctrl_reg <= 1'b0;
      tx_data_reg <= (state_next == ST_LINK_ACK) ?
                     byte_of(ack_reg, 2'd0) : 8'h00;
    end else if (tick) begin
      tx_clk_reg <= ~tx_clk_reg;
      if (tx_clk_reg) begin
        tx_idx_reg <= tx_idx_reg + 3'd1;
        tx_ctrl_reg <= (tx_idx_reg == 3'd3);
        tx_data_reg <= (tx_idx_reg == 3'd3) ? END_TOKEN :
          (tx_idx_reg == 3'd4) ? 8'h00 :
          byte_of(ack_reg, 2'(tx_idx_reg + 3'd1));
      end
    end
  end

  // Execution starts the cycle after the channel end is freed
  always_ff @(posedge clk_sys) begin
    if (!reset_n || start) begin
      exec_reg <= 1'b0;
      exec_fired_reg <= 1'b0;
    end else begin
      exec_reg <= (state_reg == ST_DONE) & ~exec_fired_reg;
      if (state_reg == ST_DONE) exec_fired_reg <= 1'b1;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign otp_rd_en = (state_reg == ST_OTP_REQ);
  assign otp_rd_addr = otp_addr_reg;
  assign spi_cs_n_o = cs_n_reg;
  assign spi_cs_n_oe = mst_en_reg;
  assign spi_sclk_o = sclk_reg;
  assign spi_sclk_oe = mst_en_reg;
  assign spi_mosi_o = cmd_sr_reg[31];
  assign spi_mosi_oe = mst_en_reg & ~quad_en_reg;
  assign quad_data_lines_o = {3'b000, cmd_sr_reg[31]};
  // Data lines released after the address so the flash can drive them
  assign quad_data_lines_oe = {3'b000,
    quad_en_reg & (state_reg == ST_SPI_CMD)};
  assign link_tx_clk = tx_clk_reg;
  assign link_tx_ctrl = tx_ctrl_reg;
  assign link_tx_data = tx_data_reg;
  assign link_enable = link_en_reg;
  assign link_pulldown_en = ~link_en_reg;
  assign img_word = img_reg;
  assign chanend0_alloc = chan_reg;
  assign exec_start = exec_reg;
  assign prot_ctl.tap_block = prot_reg[PROT_TAP_OFF];
  assign prot_ctl.switch_block = prot_reg[PROT_LINK_OFF];
  assign prot_ctl.redundant_en = prot_reg[PROT_REDUND];
  assign prot_ctl.sector_lock = prot_reg[PROT_SLOCK_LO +: 4] |
    {4{prot_reg[PROT_MLOCK]}};
  assign prot_ctl.master_lock = prot_reg[PROT_MLOCK];
  assign prot_ctl.tap_otp_block = prot_reg[PROT_TAP_OTP];
  assign prot_ctl.usercode_ext = prot_reg[31:PROT_UID_LO];
endmodule : tbs_boot_loader

// [testbench/tbs_boot_loader_assertions.sv]
/* Port checker of the boot loader.
   Bound to the loader from the bench top file; sees ports only. */
module tbs_boot_loader_assertions
  import tbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic spi_cs_n_o,
  input wire logic spi_sclk_o,
  input wire logic spi_sclk_oe,
  input wire logic spi_mosi_oe,
  input wire logic [3:0] quad_data_lines_oe,
  input wire logic link_enable,
  input wire logic link_pulldown_en,
  input wire logic exec_start,
  input wire tbs_prot_t prot_ctl,
  input wire tbs_word_t img_word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_clk_idle: assert property (spi_cs_n_o |-> !spi_sclk_o)
    else $error("serial clock high while deselected");
  a_quad_pins: assert property (|quad_data_lines_oe |->
    !spi_cs_n_o && spi_sclk_oe)
    else $error("quad lines driven without select and clock");
  a_single_pins: assert property (spi_mosi_oe |->
    spi_sclk_oe && quad_data_lines_oe == 4'h0)
    else $error("single master pins inconsistent");
  a_link_pull: assert property (link_pulldown_en == !link_enable)
    else $error("link pull-downs not released with enable");
  a_exec_pulse: assert property (exec_start |=> !exec_start)
    else $error("execution start longer than one cycle");
  a_lock_all: assert property (prot_ctl.master_lock |->
    &prot_ctl.sector_lock)
    else $error("master lock leaves a sector open");
  a_word_pulse: assert property (img_word.valid |=> !img_word.valid)
    else $error("image word strobe longer than one cycle");
  a_prot_hold: assert property ($past(reset_n, 2) |->
    $stable(prot_ctl))
    else $error("protection controls changed after capture");
  cover property (exec_start);
  cover property (img_word.valid);
  cover property ($fell(spi_cs_n_o));
  cover property ($rose(link_enable));
endmodule : tbs_boot_loader_assertions

// [testbench/tbs_flash_model.sv]
/* Quad flash model: ignores the command, then sends the image.
   Assumes mode 0 and a loader sampling at falling clock edges. */
module tbs_flash_model
  import tbs_pkg::*;
(
  // Pins
  input wire logic cs_n,
  input wire logic sclk,
  // Image, byte 0 in bits 7:0
  input wire logic [95:0] image,
  output logic [3:0] dq
);
  int falls = 0;
  initial dq = 4'h0;
  // Released lines show the inverse, never a stale value
  always @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      falls <= 0;
      dq <= ~dq;
    end else begin
      falls <= falls + 1;
      if (falls >= 31 && falls < 55)
        dq <= image[(falls - 31) * 4 +: 4];
      else dq <= ~dq;
    end
  end
endmodule : tbs_flash_model

// [testbench/tbs_boot_loader_bench.sv]
/* Bench: protection capture, register bus, quad flash and link boots.
   Assumes the flash model file and the checker are compiled first. */
module tbs_boot_loader_bench
  import tbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, otp_prot = 0, otp_data = 0;
  logic [31:0] q, w_exp, got = 0, seed = 32'he025b254;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] flash_dq, dq_pin, qoe, qo;
  logic hreadyout, cs_n, sclk, mosi, start;
  tbs_word_t img_word;
  tbs_prot_t prot_ctl;
  int failures = 0, total_checks = 0, cycles = 0;
  int booted = 0;
  logic rx_clk = 0, rx_ctrl = 0, lnk_en, tx_ctrl;
  logic [7:0] rx_data = 8'h00, tx_data, tok = 8'h00;
  logic [31:0] a;
  initial forever #5 clk_sys = ~clk_sys;
  assign dq_pin = (qoe & qo) | (~qoe & flash_dq);
  tbs_flash_model flash (.cs_n(cs_n), .sclk(sclk), .dq(flash_dq),
    .image({CRC_SKIP, w_exp, 32'h1}));
  tbs_boot_loader uut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
    .hrdata(q), .otp_prot_word(otp_prot), .otp_rd_en(), .otp_rd_addr(),
    .otp_rd_data(otp_data), .spi_cs_n_i(cs_n), .spi_cs_n_o(cs_n),
    .spi_cs_n_oe(), .spi_sclk_i(sclk), .spi_sclk_o(sclk), .spi_sclk_oe(),
    .spi_mosi_i(mosi), .spi_mosi_o(mosi), .spi_mosi_oe(),
    .spi_miso_i(dq_pin[1]), .quad_data_lines_i(dq_pin),
    .quad_data_lines_o(qo), .quad_data_lines_oe(qoe), .link_rx_clk(rx_clk),
    .link_rx_ctrl(rx_ctrl), .link_rx_data(rx_data), .link_tx_clk(),
    .link_tx_ctrl(tx_ctrl), .link_tx_data(tx_data), .link_enable(lnk_en),
    .link_pulldown_en(),
    .img_word(img_word), .chanend0_alloc(), .exec_start(start),
    .prot_ctl(prot_ctl));
  task check(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task wrap_up;
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Holds each phase until hready is seen high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask : bus
  function automatic logic [31:0] crc_of(input logic [63:0] m);
    logic [31:0] r;
    r = CRC_INIT;
    for (int i = 0; i < 64; i++) begin
      r = (r >> 1) ^ ((r[0] ^ m[i]) ? CRC_POLY : 32'h0);
    end
    return ~r;
  endfunction : crc_of
  // Data set half a link period before the rising link clock
  task link_send(input logic c, input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      rx_ctrl <= c;
      rx_data <= w[8 * i +: 8];
      repeat (8) @(posedge clk_sys);
      rx_clk <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rx_clk <= 1'b0;
    end
  endtask : link_send
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (img_word.valid === 1'b1) got <= img_word.data;
    if (start === 1'b1) booted <= booted + 1;
    if (tx_ctrl === 1'b1) tok <= tx_data;
    if (cycles == 20000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    // Secure boot kept off so the flash path is taken
    otp_prot = $random(seed) & 32'hffffffdf;
    otp_data = $random(seed);
    w_exp = $random(seed);
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("prot_ctl", {13'h0, otp_prot[0], otp_prot[1], otp_prot[7],
      otp_prot[11:8] | {4{otp_prot[12]}}, otp_prot[12], otp_prot[13],
      otp_prot[31:22]}, 32'(prot_ctl));
    bus(1'b1, REG_PROT, 32'hffffffff);
    bus(1'b0, REG_PROT, 32'h0);
    check("prot", otp_prot | 32'h003f8000, q);
    bus(1'b0, 8'hfc, 32'h0);
    check("unmapped", 32'h0, q);
    bus(1'b1, REG_CTRL, 32'h10 | 32'(SRC_QUAD));
    while (booted < 1) @(posedge clk_sys);
    check("word", w_exp, got);
    bus(1'b0, REG_WORDS, 32'h0);
    check("words", 32'h1, q);
    bus(1'b0, REG_STATUS, 32'h0);
    check("status", 32'h70, q & 32'hf0);
    bus(1'b0, REG_CRC, 32'h0);
    check("crc", crc_of({w_exp, 32'h1}), q);
    // Null acknowledge first, so no token may have been sent yet
    for (int k = 0; k < 2; k++) begin
      a = k ? $random(seed) : NULL_CHANEND;
      bus(1'b1, REG_CTRL, 32'h10 | 32'(SRC_LINK));
      do @(posedge clk_sys); while (lnk_en !== 1'b1);
      link_send(1'b0, a, 4);
      link_send(1'b0, 32'h0, 4);
      link_send(1'b0, CRC_SKIP, 4);
      link_send(1'b1, 32'(END_TOKEN), 1);
      {rx_ctrl, rx_data} <= 9'h000;
      while (booted < k + 2) @(posedge clk_sys);
      bus(1'b0, REG_ACK, 32'h0);
      check("ack", a, q);
      check("tx_token", k ? 32'(END_TOKEN) : 32'h0, 32'(tok));
    end
    wrap_up;
  end
endmodule : tbs_boot_loader_bench
bind tbs_boot_loader tbs_boot_loader_assertions chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
  .spi_cs_n_o(spi_cs_n_o), .spi_sclk_o(spi_sclk_o),
  .spi_sclk_oe(spi_sclk_oe), .spi_mosi_oe(spi_mosi_oe),
  .quad_data_lines_oe(quad_data_lines_oe), .link_enable(link_enable),
  .link_pulldown_en(link_pulldown_en), .exec_start(exec_start),
  .prot_ctl(prot_ctl), .img_word(img_word));
